// ### src/spa_dev.sv
// Contract
// [R1] bit 22 selects per-port station addresses
// [R2] per-port bits 41:40 from fields 21:16
// [R3] port fields reset 10,01,00; select 0
// [R4] high bits 15:0 hold 47:32, reset FFFFh
// [R5] low register holds 31:0, reset FF0F8000h
// [R6] 48-bit address sourced into pause frames
// [R7] programmed eeprom loads both address registers
// [R8] eeprom bytes 01h-04h fill low register
// [R9] eeprom bytes 05h,06h fill high register
// [R10] byte order follows ethernet reception order
// [R11] host writes addresses only after init
// [R12] write-only direct window at 200h-2F8h
// [R13] window write loads index, be, write, busy
// [R14] busy self-clears on completion; host watches
// [R15] window data delivered to target csr
// [R16] host never reads through the window
// [R17] general and port 0 offsets mapped
// [R18] port 1 offsets mapped
// [R19] byte enables gate bytes high to low
// [R20] direction: write 0, read 1
// [R21] host waits for busy before next
// [R22] high bits 31:23 read zero
//
// Chosen here: the AHB-Lite register port.
module spa_dev
  import spa_pkg::*;
#(
  parameter int PORTS = NUM_PORTS  // switch ports with own address
)(
  input  wire logic               MCLK_I,          // system clock
  input  wire logic               ARST_N_I,        // async reset, low
  spa_reg_if.dev                  REG,             // register port
  input  wire logic               EE_VALID_I,      // eeprom byte strobe
  input  wire logic [7:0]         EE_ADDR_I,       // eeprom byte address
  input  wire logic [7:0]         EE_DATA_I,       // eeprom byte value
  input  wire logic               EE_DONE_I,       // loader finished
  input  wire logic               CSR_DONE_I,      // fabric write done
  output logic      [15:0]        CSR_INDEX_O,     // target_csr_index
  output logic      [3:0]         TARGET_BYTE_ENABLES_O,        // target_byte_enables
  output logic                    CSR_DIR_O,       // access_direction
  output logic                    COMMAND_BUSY_FLAG_O,      // command_busy_flag
  output logic      [31:0]        CSR_WDATA_O,     // forwarded_write_value
  output logic [PORTS-1:0][47:0]  PAUSE_ADDR_O     // per-port source address
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  generate
    if (PORTS < 1 || PORT_FIELD_LSB + PORTS * PORT_FIELD_W > HI_SEL_BIT) begin : g_chk
      $error("spa_dev: port count does not fit the high register");
    end
    if (MAC_SPLIT_BIT + PORT_FIELD_W > 16 || HI_SEL_BIT != HI_USED_W - 1) begin : g_field_chk
      $error("spa_dev: high register fields overlap");
    end
    // every window table entry must be an aligned word inside the window
    for (genvar c = 0; c < DW_COUNT; c++) begin : g_tbl_chk
      if (DW_OFF[c] < DW_FIRST_OFF || DW_OFF[c] > DW_LAST_OFF ||
          DW_OFF[c][1:0] != 2'b00) begin : g_bad
        $error("spa_dev: window table entry outside the window");
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [22:0] addr_high;
  logic [31:0] addr_low;
  logic        init_done;
  logic        busy;
  logic        dw_hit;
  logic [15:0] dw_index;

  wire host_wr   = REG.req & REG.wr;
  wire sel_high  = (REG.addr == ADDR_HIGH_OFF);
  wire sel_low   = (REG.addr == ADDR_LOW_OFF);
  wire host_high = host_wr & sel_high;  // [R11]
  wire host_low  = host_wr & sel_low;   // [R11]
  wire in_window = (REG.addr >= DW_FIRST_OFF) && (REG.addr <= DW_LAST_OFF);  // [R12]
  // a window write is dropped while busy or at an unmapped offset
  wire dw_write  = host_wr & in_window;        // [R12]
  wire dw_take   = dw_write & dw_hit & ~busy;  // [R21]

  // maps a window offset to its fabric csr index
  spa_dw_map spa_dw_map_inst (
    .off_i   (REG.addr),
    .hit_o   (dw_hit),
    .index_o (dw_index)
  );

  // window reads return zero; reserved high bits read zero
  logic [31:0] rd_mux;

  always_comb begin
    if (sel_high) begin
      rd_mux = {9'h000, addr_high};  // [R22]
    end else if (sel_low) begin
      rd_mux = addr_low;
    end else begin
      rd_mux = WORD_ZERO;  // [R12]
    end
  end

  // ----------------------------------------------------------------
  // eeprom byte placement
  // ----------------------------------------------------------------
  // loads are taken only until the loader reports done
  wire       ee_hit  = EE_VALID_I && ~init_done &&
                       (EE_ADDR_I >= EE_FIRST_ADDR) && (EE_ADDR_I <= EE_LAST_ADDR);
  wire [7:0] ee_rel  = EE_ADDR_I - EE_FIRST_ADDR;
  wire [2:0] ee_byte = ee_rel[2:0];
  wire       ee_low  = (ee_byte < EE_LOW_BYTES);
  // bytes past the fourth land in the high register
  wire [2:0] hi_byte = ee_byte - EE_LOW_BYTES;

  // ----------------------------------------------------------------
  // address registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      addr_high <= HIGH_RESET;  // [R3] [R4]
      addr_low  <= LOW_RESET;   // [R5]
      init_done <= 1'b0;
    end else begin
      if (EE_DONE_I) begin
        init_done <= 1'b1;
      end
      if (ee_hit) begin  // [R7] [R10]
        if (ee_low) begin
          addr_low[ee_byte[1:0]*8 +: 8] <= EE_DATA_I;  // [R8]
        end else begin
          addr_high[hi_byte[0]*8 +: 8] <= EE_DATA_I;   // [R9]
        end
      end else if (host_high) begin  // eeprom bytes win a same-cycle clash
        addr_high <= REG.wdata[HI_USED_W-1:0];  // [R1] [R22]
      end else if (host_low) begin
        addr_low <= REG.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // forwarded fabric write command
  // ----------------------------------------------------------------
  // busy is set only while clear, so set and clear never meet
  wire        next_busy  = dw_take | (busy & ~CSR_DONE_I);      // [R13] [R14]
  wire [15:0] next_index = dw_take ? dw_index  : CSR_INDEX_O;  // [R17] [R18]
  wire [3:0]  next_be    = dw_take ? BE_ALL    : TARGET_BYTE_ENABLES_O;     // [R19]
  wire        next_dir   = dw_take ? DIR_WRITE : CSR_DIR_O;    // [R20]
  wire [31:0] next_wdata = dw_take ? REG.wdata : CSR_WDATA_O;  // [R15]

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      CSR_INDEX_O <= INDEX_RESET;
      TARGET_BYTE_ENABLES_O    <= BE_RESET;
      CSR_DIR_O   <= DIR_WRITE;
      CSR_WDATA_O <= DW_DATA_RESET;
      busy        <= 1'b0;
    end else begin
      CSR_INDEX_O <= next_index;
      TARGET_BYTE_ENABLES_O    <= next_be;
      CSR_DIR_O   <= next_dir;
      CSR_WDATA_O <= next_wdata;
      busy        <= next_busy;
    end
  end

  assign COMMAND_BUSY_FLAG_O = busy;

  // ----------------------------------------------------------------
  // register port answer
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      REG.ack   <= 1'b0;
      REG.rdata <= WORD_ZERO;
    end else begin
      // every request, read or write, is answered on the next edge
      REG.ack   <= REG.req;
      REG.rdata <= REG.req ? rd_mux : REG.rdata;
    end
  end

  assign REG.init_done = init_done;
  assign REG.busy      = busy;

  // ----------------------------------------------------------------
  // per-port pause source addresses
  // ----------------------------------------------------------------
  wire       per_port   = addr_high[HI_SEL_BIT];  // [R1]
  // parts of the 48-bit address shared by every port
  wire [5:0] addr_top   = addr_high[15:MAC_SPLIT_BIT+2];
  wire [1:0] addr_split = addr_high[MAC_SPLIT_BIT +: PORT_FIELD_W];
  wire [7:0] addr_fifth = addr_high[MAC_SPLIT_BIT-1:0];

  genvar p;
  generate
    for (p = 0; p < PORTS; p++) begin : g_port
      wire [1:0]  own_bits = addr_high[PORT_FIELD_LSB + p*PORT_FIELD_W +: PORT_FIELD_W];
      // address bits 41:40 come from the port field while per-port is on
      wire [1:0]  bits4140 = per_port ? own_bits : addr_split;  // [R2] [R4]
      wire [47:0] src_addr = {addr_top, bits4140, addr_fifth, addr_low};  // [R10]
      always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
          PAUSE_ADDR_O[p] <= 48'h0000_0000_0000;
        end else begin
          PAUSE_ADDR_O[p] <= src_addr;  // [R6]
        end
      end
    end
  endgenerate

endmodule : spa_dev

// ### src/spa_pkg.sv
package spa_pkg;

  // ----------------------------------------------------------------
  // device register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_HIGH_OFF   = 12'h1F0;
  localparam logic [11:0] ADDR_LOW_OFF    = 12'h1F4;
  localparam logic [11:0] DW_FIRST_OFF    = 12'h200;
  localparam logic [11:0] DW_LAST_OFF     = 12'h2F8;

  localparam int          HI_USED_W       = 23;
  localparam int          HI_SEL_BIT      = 22;
  localparam int          PORT_FIELD_LSB  = 16;
  localparam int          PORT_FIELD_W    = 2;
  localparam int          NUM_PORTS       = 3;
  localparam int          MAC_SPLIT_BIT   = 8;
  localparam logic [22:0] HIGH_RESET      = 23'h24_FFFF;
  localparam logic [31:0] LOW_RESET       = 32'hFF0F_8000;
  localparam logic [31:0] DW_DATA_RESET   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // eeprom byte addresses of the station address
  // ----------------------------------------------------------------
  localparam logic [7:0]  EE_FIRST_ADDR   = 8'h01;
  localparam logic [7:0]  EE_LAST_ADDR    = 8'h06;
  localparam logic [2:0]  EE_LOW_BYTES    = 3'h4;

  // ----------------------------------------------------------------
  // forwarded fabric command
  // ----------------------------------------------------------------
  localparam logic [3:0]  BE_ALL          = 4'hF;
  localparam logic [3:0]  BE_RESET        = 4'h0;
  localparam logic        DIR_WRITE       = 1'b0;
  localparam logic        DIR_READ        = 1'b1;
  localparam logic [15:0] INDEX_RESET     = 16'h0000;

  localparam int          DW_COUNT        = 12;
  localparam logic [11:0] DW_OFF [DW_COUNT] = '{
    12'h200, 12'h204, 12'h208, 12'h20C, 12'h210, 12'h214,
    12'h218, 12'h21C, 12'h220, 12'h2E8, 12'h2EC, 12'h224};
  localparam logic [15:0] DW_IDX [DW_COUNT] = '{
    16'h0001, 16'h0004, 16'h0401, 16'h0440, 16'h0441, 16'h0480,
    16'h0801, 16'h0840, 16'h0841, 16'h0842, 16'h0843, 16'h0880};

  // ----------------------------------------------------------------
  // controller registers on the ahb side
  // ----------------------------------------------------------------
  localparam logic [7:0]  HC_CMD_OFF      = 8'h00;
  localparam logic [7:0]  HC_WDATA_OFF    = 8'h04;
  localparam logic [7:0]  HC_RDATA_OFF    = 8'h08;
  localparam logic [7:0]  HC_STATUS_OFF   = 8'h0C;
  localparam int          CMD_READ_BIT    = 16;
  localparam int          ST_PENDING_BIT  = 0;
  localparam int          ST_INIT_BIT     = 1;
  localparam int          ST_BUSY_BIT     = 2;
  localparam int          ST_REFUSED_BIT  = 3;
  localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;
  localparam logic [11:0] OFF_ZERO        = 12'h000;

endpackage : spa_pkg

// ### src/spa_reg_if.sv
interface spa_reg_if;
  logic        req;
  logic        wr;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        ack;
  logic        init_done;
  logic        busy;

  modport dev  (input req, wr, addr, wdata, output rdata, ack, init_done, busy);
  modport host (output req, wr, addr, wdata, input rdata, ack, init_done, busy);
endinterface : spa_reg_if

// ### src/spa_dw_map.sv
module spa_dw_map
  import spa_pkg::*;
(
  input  wire logic [11:0] off_i,   // register offset of the write
  output logic             hit_o,   // offset is a mapped window word
  output logic [15:0]      index_o  // fabric csr index for the offset
);

  // ----------------------------------------------------------------
  // one comparator per table entry, or-reduced
  // ----------------------------------------------------------------
  logic [DW_COUNT-1:0] match;
  logic [15:0]         part [DW_COUNT];
  logic [15:0]         acc  [DW_COUNT+1];

  assign acc[0] = INDEX_RESET;

  genvar g;
  generate
    for (g = 0; g < DW_COUNT; g++) begin : g_ent
      assign match[g]  = (off_i == DW_OFF[g]);
      assign part[g]   = match[g] ? DW_IDX[g] : INDEX_RESET;
      assign acc[g+1]  = acc[g] | part[g];
    end
  endgenerate

  assign hit_o   = |match;
  assign index_o = acc[DW_COUNT];

endmodule : spa_dw_map

// ### src/spa_host.sv
module spa_host
  import spa_pkg::*;
(
  input  wire logic        MCLK_I,       // system clock
  input  wire logic        ARST_N_I,     // async reset, low
  input  wire logic        HSEL_I,       // ahb slave select
  input  wire logic [31:0] HADDR_I,      // ahb address
  input  wire logic [1:0]  HTRANS_I,     // ahb transfer type
  input  wire logic        HWRITE_I,     // ahb write
  input  wire logic [2:0]  HSIZE_I,      // ahb size, word only
  input  wire logic [31:0] HWDATA_I,     // ahb write data
  input  wire logic        HREADY_I,     // ahb bus ready
  output logic      [31:0] HRDATA_O,     // ahb read data
  output logic             HREADYOUT_O,  // ahb slave ready
  output logic             HRESP_O,      // ahb response, okay
  spa_reg_if.host          REG           // device register port
);

  // ----------------------------------------------------------------
  // ahb slave
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_WAIT = 4'b0010,
    S_REQ  = 4'b0100,
    S_ACK  = 4'b1000
  } spa_state_t;

  spa_state_t  state;
  logic        dp_wr;
  logic [7:0]  dp_off;
  logic [11:0] cmd_off;
  logic        cmd_read;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        refused;

  wire        ap_take  = HSEL_I & HTRANS_I[1] & HREADY_I;
  wire [7:0]  ap_off   = HADDR_I[7:0];
  wire        cmd_wr   = dp_wr && (dp_off == HC_CMD_OFF);
  wire        wdat_wr  = dp_wr && (dp_off == HC_WDATA_OFF);
  wire [11:0] new_off  = HWDATA_I[11:0];
  wire        new_rd   = HWDATA_I[CMD_READ_BIT];
  wire        new_win  = (new_off >= DW_FIRST_OFF) && (new_off <= DW_LAST_OFF);
  wire        cmd_win  = (cmd_off >= DW_FIRST_OFF) && (cmd_off <= DW_LAST_OFF);
  wire        pending  = (state != S_IDLE);
  wire [31:0] status   = {28'h000_0000, refused, REG.busy, REG.init_done, pending};
  wire [31:0] rd_mux   = (ap_off == HC_CMD_OFF)    ? {15'h0000, cmd_read, 4'h0, cmd_off} :
                         (ap_off == HC_WDATA_OFF)  ? wdata :
                         (ap_off == HC_RDATA_OFF)  ? rdata :
                         (ap_off == HC_STATUS_OFF) ? status : WORD_ZERO;
  wire        may_go   = REG.init_done && !(cmd_win && REG.busy);  // [R11] [R21]

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      dp_wr       <= 1'b0;
      dp_off      <= HC_CMD_OFF;
      HRDATA_O    <= WORD_ZERO;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      dp_wr  <= ap_take & HWRITE_I;
      dp_off <= ap_off;
      if (ap_take && !HWRITE_I) begin
        HRDATA_O <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state     <= S_IDLE;
      cmd_off   <= OFF_ZERO;
      cmd_read  <= 1'b0;
      wdata     <= WORD_ZERO;
      rdata     <= WORD_ZERO;
      refused   <= 1'b0;
      REG.req   <= 1'b0;
      REG.wr    <= 1'b0;
      REG.addr  <= OFF_ZERO;
      REG.wdata <= WORD_ZERO;
    end else begin
      if (wdat_wr && !pending) begin
        wdata <= HWDATA_I;
      end
      case (state)
        S_IDLE: begin
          if (cmd_wr) begin
            cmd_off  <= new_off;
            cmd_read <= new_rd;
            refused  <= new_rd && new_win;  // [R16]
            if (!(new_rd && new_win)) begin
              state <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          if (may_go) begin
            REG.req   <= 1'b1;
            REG.wr    <= ~cmd_read;
            REG.addr  <= cmd_off;
            REG.wdata <= wdata;
            state     <= S_REQ;
          end
        end
        S_REQ: begin
          REG.req <= 1'b0;
          state   <= S_ACK;
        end
        S_ACK: begin
          if (REG.ack) begin
            if (cmd_read) begin
              rdata <= REG.rdata;
            end
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule : spa_host

// ### tb/spa_checker.sv
module spa_checker
  import spa_pkg::*;
(
  input wire logic        MCLK_I,     // system clock
  input wire logic        ARST_N_I,   // async reset, low
  input wire logic        req,        // register request
  input wire logic        wr,         // write request
  input wire logic [11:0] addr,       // register offset
  input wire logic [31:0] wdata,      // write data
  input wire logic [31:0] rdata,      // read data
  input wire logic        ack,        // request answered
  input wire logic        init_done,  // power-on load over
  input wire logic        busy        // command busy flag
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I);

  wire in_win = (addr >= DW_FIRST_OFF) && (addr <= DW_LAST_OFF);
  wire mapped = addr inside {12'h200, 12'h204, 12'h208, 12'h20C, 12'h210, 12'h214,
                             12'h218, 12'h21C, 12'h220, 12'h224, 12'h2E8, 12'h2EC};

  // ----------------------------------------------------------------
  // request and answer
  // ----------------------------------------------------------------
  sequence s_req;     req; endsequence
  sequence s_win_wr;  req && wr && mapped && !busy; endsequence
  sequence s_win_rd;  req && !wr && in_win; endsequence
  sequence s_high_rd; req && !wr && addr == ADDR_HIGH_OFF; endsequence

  ack_follows_req_a: assert property (s_req |=> ack)
    else $error("ack missing one cycle after request");
  ack_needs_req_a: assert property (ack |-> $past(req))
    else $error("ack without request");
  req_spacing_a: assert property (s_req |=> !req [*2])
    else $error("requests closer than three cycles");
  req_after_init_a: assert property (req |-> init_done)
    else $error("request before initialization done");
  init_sticky_a: assert property (init_done |=> init_done)
    else $error("init done dropped");
  win_sets_busy_a: assert property (s_win_wr |=> busy && ack)
    else $error("window write did not set busy");
  busy_cause_a: assert property ($rose(busy) |-> $past(req && wr && in_win))
    else $error("busy set without window write");
  win_read_zero_a: assert property (s_win_rd |=> rdata == WORD_ZERO)
    else $error("window read returned data");
  win_rd_block_a: assert property (req && in_win |-> wr)
    else $error("window read request issued");
  high_rsvd_zero_a: assert property (s_high_rd |=> rdata[31:23] == 9'h000)
    else $error("reserved high bits not zero");
endmodule : spa_checker

// ### tb/switch_pause_addr_and_direct_csr_write_tb.sv
module switch_pause_addr_and_direct_csr_write_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spa_pkg::*;

  logic             mclk, arst_n, hsel, hwrite, hready, hresp;
  logic             ee_valid, ee_done, csr_done, csr_dir, command_busy_flag;
  logic [1:0]       htrans;
  logic [31:0]      haddr, hwdata, hrdata, rd, d;
  logic [7:0]       ee_addr, ee_data;
  logic [15:0]      csr_index;
  logic [3:0]       target_byte_enables;
  logic [31:0]      csr_wdata;
  logic [2:0][47:0] pause;
  int               n_errors, cmp_count;
  int               cyc = 0;
  logic [11:0] w_off [12] = '{12'h200, 12'h204, 12'h208, 12'h20C, 12'h210, 12'h214,
                              12'h218, 12'h21C, 12'h220, 12'h224, 12'h2E8, 12'h2EC};
  logic [15:0] w_idx [12] = '{16'h0001, 16'h0004, 16'h0401, 16'h0440, 16'h0441, 16'h0480,
                              16'h0801, 16'h0840, 16'h0841, 16'h0880, 16'h0842, 16'h0843};

  spa_reg_if reg_if ();
  spa_host spa_host_inst (.MCLK_I(mclk), .ARST_N_I(arst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .REG(reg_if));
  spa_dev #(.PORTS(3)) spa_dev_inst (.MCLK_I(mclk), .ARST_N_I(arst_n), .REG(reg_if),
    .EE_VALID_I(ee_valid), .EE_ADDR_I(ee_addr), .EE_DATA_I(ee_data), .EE_DONE_I(ee_done),
    .CSR_DONE_I(csr_done), .CSR_INDEX_O(csr_index), .TARGET_BYTE_ENABLES_O(target_byte_enables), .CSR_DIR_O(csr_dir),
    .COMMAND_BUSY_FLAG_O(command_busy_flag), .CSR_WDATA_O(csr_wdata), .PAUSE_ADDR_O(pause));
  spa_checker spa_checker_inst (.MCLK_I(mclk), .ARST_N_I(arst_n), .req(reg_if.req),
    .wr(reg_if.wr), .addr(reg_if.addr), .wdata(reg_if.wdata), .rdata(reg_if.rdata),
    .ack(reg_if.ack), .init_done(reg_if.init_done), .busy(reg_if.busy));

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge mclk);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb

  // device command through the controller, waits until no longer pending
  task automatic dcmd(input logic [31:0] cmd, input logic [31:0] wd);
    int k;
    k = 0;
    ahb(1'b1, 32'h0000_0004, wd, rd);
    ahb(1'b1, 32'h0000_0000, cmd, rd);
    do begin
      ahb(1'b0, 32'h0000_000C, 32'h0000_0000, rd);
      k++;
    end while (rd[0] !== 1'b0 && k < 40);
  endtask : dcmd

  task automatic ee(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    ee_valid <= 1'b1; ee_addr <= a; ee_data <= v;
    @(posedge mclk);
    ee_valid <= 1'b0;
  endtask : ee

  // ----------------------------------------------------------------
  // clock, timeout and tests
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  initial begin
    arst_n = 1'b0; hsel = 1'b0; htrans = 2'b00; haddr = '0; hwrite = 1'b0; hwdata = '0;
    ee_valid = 1'b0; ee_addr = '0; ee_data = '0; ee_done = 1'b0; csr_done = 1'b0;
    n_errors = 0; cmp_count = 0;
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int p = 0; p < 3; p++) chk(pause[p], 48'hFFFF_FF0F_8000);
    for (int i = 1; i <= 6; i++) ee(i[7:0], 8'h11 * i[7:0]);
    @(posedge mclk) ee_done <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int p = 0; p < 3; p++) chk(pause[p], 48'h6655_4433_2211);
    dcmd(32'h0001_01F0, 32'h0000_0000);
    ahb(1'b0, 32'h0000_0008, 32'h0000_0000, rd);
    chk(rd, 32'h0024_6655);
    dcmd(32'h0000_01F0, 32'hFFF9_1234);
    dcmd(32'h0000_01F4, 32'hA5A5_5A5A);
    dcmd(32'h0001_01F0, 32'h0000_0000);
    ahb(1'b0, 32'h0000_0008, 32'h0000_0000, rd);
    chk(rd, 32'h0079_1234);
    chk(pause[0], 48'h1134_A5A5_5A5A);
    chk(pause[1], 48'h1234_A5A5_5A5A);
    chk(pause[2], 48'h1334_A5A5_5A5A);
    for (int i = 0; i < 12; i++) begin
      d = {16'hC0DE, 4'h0, w_off[i]};
      dcmd({20'h0_0000, w_off[i]}, d);
      chk(csr_index, w_idx[i]);
      chk(target_byte_enables, 4'hF);
      chk(csr_dir, 1'b0);
      chk(csr_wdata, d);
      chk(command_busy_flag, 1'b1);
      if (i == 0) begin
        // a second window write is held by the controller until busy clears
        ahb(1'b1, 32'h0000_0004, 32'h5555_5555, rd);
        ahb(1'b1, 32'h0000_0000, 32'h0000_0204, rd);
        repeat (8) @(posedge mclk);
        chk(csr_index, 16'h0001);
        chk(csr_wdata, d);
        ahb(1'b0, 32'h0000_000C, 32'h0000_0000, rd);
        chk(rd[0], 1'b1);
        @(posedge mclk) csr_done <= 1'b1;
        @(posedge mclk) csr_done <= 1'b0;
        repeat (8) @(posedge mclk);
        chk(csr_index, 16'h0004);
        chk(csr_wdata, 32'h5555_5555);
        chk(command_busy_flag, 1'b1);
      end
      ahb(1'b0, 32'h0000_000C, 32'h0000_0000, rd);
      chk(rd[2], 1'b1);
      @(posedge mclk) csr_done <= 1'b1;
      @(posedge mclk) csr_done <= 1'b0;
      @(posedge mclk);
      chk(command_busy_flag, 1'b0);
    end
    dcmd(32'h0000_0230, 32'h0000_0001);
    chk(command_busy_flag, 1'b0);
    chk(csr_index, 16'h0843);
    dcmd(32'h0001_0208, 32'h0000_0000);
    ahb(1'b0, 32'h0000_0008, 32'h0000_0000, rd);
    // a refused window read leaves the last device read in place
    chk(rd, 32'h0079_1234);
    ahb(1'b0, 32'h0000_000C, 32'h0000_0000, rd);
    chk(rd[3], 1'b1);
    ahb(1'b0, 32'h0000_0040, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    chk(hresp, 1'b0);
    end_of_test();
  end
endmodule : switch_pause_addr_and_direct_csr_write_tb
